// ---- hdl/rie_params.svh ----
// Constants for the return instruction executor.
// What this block does
// RULE1: The interrupt return pops the return stack and loads the popped top entry into the program counter.
// RULE2: The interrupt return sets the global interrupt enable, bit 7 of the interrupt control register.
// RULE3: The interrupt return is one program word with no operands and takes two instruction cycles.
// RULE4: The literal return writes its 8-bit operand into the working register and touches no status flag.
// RULE5: The literal return also loads the program counter from the top of stack in two cycles.
// RULE6: The plain return pops the stack into the program counter with no operands and no flag change.
// RULE7: The plain return takes two instruction cycles like the other two returns.
// RULE8: In the second cycle of each return the fetched next instruction is discarded and nothing runs.
`ifndef RIE_PARAMS_SVH
`define RIE_PARAMS_SVH
`define RIE_GLB_IE_BIT      7
`define RIE_OP_RETURN       14'h0008
`define RIE_OP_RETINT       14'h0009
`define RIE_OP_LIT_MASK     14'h3C00
`define RIE_OP_LIT_CODE     14'h3400
`define RIE_ICTRL_RESET     8'h00
`define RIE_PC_RESET        13'h0000
`define RIE_W_RESET         8'h00
`endif

// ---- hdl/rie_pkg.sv ----
// Types shared by the return instruction executor.
package rie_pkg;
    typedef enum logic [1:0] {
        RIE_IDLE  = 2'b01,
        RIE_FLUSH = 2'b10
    } rie_state_e;
endpackage

// ---- hdl/rie_return_exec.sv ----
// Execution of the three return instructions: stack pop, working register and enable.
`include "rie_params.svh"
module rie_return_exec #(
    parameter int PC_W  = 13,
    parameter int OP_W  = 14
) (
    input  wire logic            clk,           // Core instruction clock.
    input  wire logic            nrst,          // Asynchronous reset, active low.
    input  wire logic            instr_valid,   // Fetched instruction word is valid this cycle.
    input  wire logic [OP_W-1:0] instr_word,    // Fetched instruction word.
    input  wire logic [PC_W-1:0] top_of_stack,  // Current top entry of the return stack.
    input  wire logic [7:0]      int_ctrl_in,   // Interrupt control register as held by the core.
    output logic                 stack_pop,     // One-cycle pulse popping the return stack.
    output logic                 pc_load,       // One-cycle pulse loading the program counter.
    output logic [PC_W-1:0]      pc_value,      // Address to load into the program counter.
    output logic                 w_load,        // One-cycle pulse writing the working register.
    output logic [7:0]           w_value,       // Value for the working register.
    output logic                 int_ctrl_load, // One-cycle pulse writing the interrupt control.
    output logic [7:0]           int_ctrl_value, // New interrupt control register value.
    output logic                 flush,         // High in the discarded second cycle.
    output logic                 busy           // High in the second cycle of a return, the discarded slot.
);
    logic rst_sync1_reg;
    logic rst_sync2_reg;

    // Reset release through two flip-flops so every register leaves reset together.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end

    rie_pkg::rie_state_e state_reg, state_next;
    logic            pop_reg, pop_next;
    logic            pcl_reg, pcl_next;
    logic [PC_W-1:0] pcv_reg, pcv_next;
    logic            wl_reg, wl_next;
    logic [7:0]      wv_reg, wv_next;
    logic            il_reg, il_next;
    logic [7:0]      iv_reg, iv_next;
    logic            is_ret, is_rfi, is_lit, any_ret;

    // Decode of the three return opcodes; the literal form carries k in the low byte.
    always_comb begin
        is_ret  = (instr_word == `RIE_OP_RETURN);
        is_rfi  = (instr_word == `RIE_OP_RETINT);
        is_lit  = ((instr_word & `RIE_OP_LIT_MASK) == `RIE_OP_LIT_CODE);
        any_ret = instr_valid && (is_ret || is_rfi || is_lit);
    end

    // Every effect is decoded in the first cycle and pulses, registered, in the second, where the prefetch is discarded.
    // Status flags are never touched, so no status output exists at all.
    always_comb begin
        state_next = state_reg;
        pop_next   = 1'b0;
        pcl_next   = 1'b0;
        pcv_next   = pcv_reg;
        wl_next    = 1'b0;
        wv_next    = wv_reg;
        il_next    = 1'b0;
        iv_next    = iv_reg;
        case (state_reg)
            rie_pkg::RIE_IDLE: begin
                if (any_ret) begin
                    pop_next   = 1'b1;                            // RULE1
                    pcl_next   = 1'b1;                            // RULE6
                    pcv_next   = top_of_stack;                    // RULE5
                    state_next = rie_pkg::RIE_FLUSH;              // RULE3
                    if (is_lit) begin
                        wl_next = 1'b1;                           // RULE4
                        wv_next = instr_word[7:0];                // RULE4
                    end
                    if (is_rfi) begin
                        il_next = 1'b1;                           // RULE2
                        iv_next = int_ctrl_in;
                        iv_next[`RIE_GLB_IE_BIT] = 1'b1;          // RULE2
                    end
                end
            end
            rie_pkg::RIE_FLUSH: begin
                // The fetched word is ignored here, so a return cannot chain mid-flush.
                state_next = rie_pkg::RIE_IDLE;                   // RULE7 RULE8
            end
            default: state_next = rie_pkg::RIE_IDLE;
        endcase
    end

    // Registering stage; all outputs come straight from these flip-flops.
    always_ff @(posedge clk or negedge rst_sync2_reg) begin
        if (!rst_sync2_reg) begin
            state_reg <= rie_pkg::RIE_IDLE;
            pop_reg   <= 1'b0;
            pcl_reg   <= 1'b0;
            pcv_reg   <= `RIE_PC_RESET;
            wl_reg    <= 1'b0;
            wv_reg    <= `RIE_W_RESET;
            il_reg    <= 1'b0;
            iv_reg    <= `RIE_ICTRL_RESET;
        end else begin
            state_reg <= state_next;
            pop_reg   <= pop_next;
            pcl_reg   <= pcl_next;
            pcv_reg   <= pcv_next;
            wl_reg    <= wl_next;
            wv_reg    <= wv_next;
            il_reg    <= il_next;
            iv_reg    <= iv_next;
        end
    end

    // State codes are one-hot, so flush and busy are plain bits of the state register.
    always_comb begin
        stack_pop    = pop_reg;
        pc_load      = pcl_reg;
        pc_value     = pcv_reg;
        w_load       = wl_reg;
        w_value      = wv_reg;
        int_ctrl_load  = il_reg;
        int_ctrl_value = iv_reg;
        flush        = state_reg[1];                              // RULE8
        busy         = state_reg[1];
    end
endmodule

// ---- sim/rie_return_exec_properties.sv ----
// Port checker for the return executor.
module rie_return_exec_properties #(
    parameter int PC_W = 13,
    parameter int OP_W = 14
) (
    input wire logic            clk,            // Core clock.
    input wire logic            nrst,           // Reset, active low.
    input wire logic            instr_valid,    // Word valid.
    input wire logic            stack_pop,      // Pop pulse.
    input wire logic            pc_load,        // Counter load pulse.
    input wire logic            w_load,         // Working register load pulse.
    input wire logic            int_ctrl_load,  // Interrupt control load pulse.
    input wire logic            flush,          // Discarded slot.
    input wire logic            busy,           // Second cycle of a return.
    input wire logic [OP_W-1:0] instr_word,     // Fetched word.
    input wire logic [PC_W-1:0] top_of_stack,   // Stack top.
    input wire logic [PC_W-1:0] pc_value,       // Counter value.
    input wire logic [7:0]      int_ctrl_in,    // Interrupt control now.
    input wire logic [7:0]      int_ctrl_value, // Interrupt control new value.
    input wire logic [7:0]      w_value         // Working register value.
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Busy marks the discarded slot, so a return is only taken while idle.
    wire logic lit = instr_word[13:10] == 4'hD;
    wire logic irq = instr_word == 14'h0009;
    wire logic ret = instr_valid && !busy && (lit || irq || instr_word == 14'h0008);
    pop_load_a: assert property (ret |=> stack_pop && pc_load &&
        pc_value == $past(top_of_stack)) else $error("No pop.");
    gie_set_a: assert property (ret && irq |=> int_ctrl_load &&
        int_ctrl_value == ($past(int_ctrl_in) | 8'h80)) else $error("No enable.");
    lit_w_a: assert property (ret && lit |=> w_load &&
        w_value == $past(instr_word[7:0])) else $error("No literal.");
    two_cyc_a: assert property (ret |=> busy ##1 !busy) else $error("Length.");
    stray_w_a: assert property (w_load |-> $past(ret) && $past(lit))
        else $error("Stray W.");
    stray_ie_a: assert property (int_ctrl_load |-> $past(ret) && $past(irq))
        else $error("Stray enable.");
    pop_why_a: assert property (stack_pop |-> flush && $past(ret)) else $error("Pop.");
    slot_nop_a: assert property (flush |=> !pc_load && !w_load) else $error("Slot.");
    c_irq: cover property (ret && irq);
    c_lit: cover property (ret && lit);
    c_slot: cover property (busy && instr_valid && irq);
    c_plain: cover property (ret && instr_word == 14'h0008);
endmodule
bind rie_return_exec rie_return_exec_properties #(.PC_W(PC_W), .OP_W(OP_W)) i_props (.*);

// ---- sim/rie_core_model.sv ----
// Core side model: return stack and interrupt control register.
module rie_core_model (
    input  wire logic        clk,            // Core clock.
    input  wire logic        push,           // Call pushes a return address.
    input  wire logic        stack_pop,      // Pop from the executor.
    input  wire logic        int_ctrl_load,  // Interrupt control write.
    input  wire logic [12:0] push_addr,      // Address pushed by a call.
    input  wire logic [7:0]  int_ctrl_value, // Value written by the executor.
    output logic      [12:0] top_of_stack,   // Current stack top.
    output logic      [7:0]  int_ctrl_in     // Interrupt control as held.
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [12:0] stk [0:7] = '{default: 13'h0000};
    logic [2:0] sp = 3'h0;
    logic [7:0] ctrl_reg = 8'h00;
    assign top_of_stack = stk[sp];
    assign int_ctrl_in = ctrl_reg;
    // A call masks interrupts, so only the executor can set the enable again.
    always @(posedge clk) begin
        if (push) begin
            stk[sp + 3'h1] <= push_addr;
            sp <= sp + 3'h1;
            ctrl_reg <= {1'b0, push_addr[6:0]};
        end else if (stack_pop) sp <= sp - 3'h1;
        if (int_ctrl_load) ctrl_reg <= int_ctrl_value;
    end
endmodule

// ---- sim/rie_return_exec_tb.sv ----
// Bench for the return executor against the core model.
module rie_return_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, nrst = 1'b0, instr_valid = 1'b0, push = 1'b0;
    logic stack_pop, pc_load, w_load, int_ctrl_load, flush, busy;
    logic [13:0] instr_word = 14'h0000;
    logic [12:0] push_addr = 13'h0000, top_of_stack, pc_value;
    logic [7:0] int_ctrl_in, w_value, int_ctrl_value;
    logic [31:0] r;
    logic [30:0] exp;
    logic [30:0] notes [$];
    int failures = 0, comparisons = 0, cycles = 0, seed = 27566;
    rie_return_exec i_rie_return_exec (.*);
    rie_core_model i_rie_core_model (.*);
    initial forever #4 clk = ~clk;
    task automatic test_done;
        if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic ok);
        comparisons++;
        if (ok !== 1'b1) begin
            failures++;
            $display("[ERR] %0t result differs", $time);
        end
    endtask
    // A hang costs a mismatch; the run needs about 200 cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles > 1000) begin
            failures++;
            test_done();
        end
    end
    // Every load is matched to the oldest note; a load with no note fails.
    always @(negedge clk) if (pc_load === 1'b1) begin
        exp = notes.size() ? notes.pop_front() : 'x;
        chk(pc_value === exp[28:16] && stack_pop === 1'b1 && flush === 1'b1);
        chk(busy === 1'b1);
        chk(w_load === exp[30] && (!exp[30] || w_value === exp[15:8]));
        chk(int_ctrl_load === exp[29] && (!exp[29] || int_ctrl_value === exp[7:0]));
    end
    // Push a return address, issue a word, then, when that word is a return and r[4] is set, offer a return in the discarded slot.
    initial begin
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        for (int i = 0; i < 60; i++) begin
            r = $random(seed);
            push = 1'b1;
            push_addr = r[28:16];
            @(negedge clk);
            push = 1'b0;
            instr_valid = 1'b1;
            instr_word = r[1] ? {4'h0, r[9:0]} | (r[0] ? 14'h0100 : 14'h3400) : {13'h0004, r[0]};
            if (r[1:0] != 2'd3)
                notes.push_back({r[1:0] == 2'd2, r[1:0] == 2'd1, r[28:16], r[7:0], 1'b1, r[22:16]});
            @(negedge clk);
            instr_valid = r[4] && r[1:0] != 2'd3;
            instr_word = {13'h0004, r[2]};
            @(negedge clk);
            instr_valid = 1'b0;
        end
        repeat (3) @(negedge clk);
        chk(notes.size() == 0);
        test_done();
    end
endmodule
